// ===== verilog/ccpm_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts for the
 * CPU clock and power manager.
 * Assumes a 32-bit APB bus with word-aligned registers.
 */
`ifndef CCPM_REGS_SVH
`define CCPM_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CCPM_OFS_PWR_CTRL 12'h000
`define CCPM_OFS_DIVIDER 12'h004
`define CCPM_OFS_AUX_CTRL 12'h008
`define CCPM_OFS_IRQ_EN 12'h00C
`define CCPM_OFS_CONFIG 12'h010
`define CCPM_OFS_STATUS 12'h014

// ****************************************************************
// Field positions
// ****************************************************************
`define CCPM_PC_DOZE 0
`define CCPM_PC_SLEEP 1
`define CCPM_PC_GF0 2
`define CCPM_PC_GF1 3
`define CCPM_PC_POF 4
`define CCPM_PC_BOF 5
`define CCPM_AUX_BOI 5
`define CCPM_AUX_BOD 6
`define CCPM_IE_EBO 5
`define CCPM_IE_EA 7
`define CCPM_CFG_HALF 0
`define CCPM_CFG_BOV 1
`define CCPM_CFG_XTAL 2

// ****************************************************************
// Reset values
// ****************************************************************
`define CCPM_RST_PC 8'h30
`define CCPM_RST_DIV 8'h00
`define CCPM_RST_AUX 8'h00
`define CCPM_RST_IE 8'h00
`define CCPM_RST_CFG 8'h02

// ****************************************************************
// Timing counts in CPU clocks
// ****************************************************************
`define CCPM_WAKE_XTAL 11'h400
`define CCPM_WAKE_RC 11'h100

`endif

// ===== verilog/ccpm_pkg.sv
/*
 * Types shared by the CPU clock and power manager files.
 * Assumes the register header is included alongside.
 */
package ccpm_pkg;

    // Power state of the core, one-hot.
    typedef enum logic [3:0] {
        CCPM_RUN = 4'h1,
        CCPM_IDLE = 4'h2,
        CCPM_DOWN = 4'h4,
        CCPM_WAKE = 4'h8
    } ccpm_state_e;

    // Synchronised detector levels.
    typedef struct packed {
        logic brownout;
        logic power_on;
        logic watchdog;
    } ccpm_det_s;

endpackage : ccpm_pkg

// ===== verilog/ccpm_divider.sv
/*
 * CPU clock enable generator: halving option and programmable divider.
 * Assumes clk is the oscillator and the divider value may change anytime.
 */
module ccpm_divider
    import ccpm_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Control.
    input wire logic run,
    input wire logic half_speed_compat,
    input wire logic [7:0] cpu_clock_divider,
    // Output enable pulse.
    output logic cpu_clk_en
);

    // ****************************************************************
    // Counter
    // ****************************************************************
    logic [9:0] count; // Oscillator clocks since last pulse.
    logic [9:0] next_count;
    logic [9:0] limit; // Ratio minus one.
    logic next_en;

    // Works out the ratio; a new value only moves the terminal count.
    always_comb begin
        if (cpu_clock_divider == 8'h00) begin
            limit = half_speed_compat ? 10'h001 : 10'h000;
        end else begin
            limit = ({1'b0, cpu_clock_divider, 1'b0} + 10'h002) *
                (half_speed_compat ? 10'h002 : 10'h001) - 10'h001;
        end
        next_count = count;
        next_en = 1'b0;
        if (run) begin
            if (count >= limit) begin
                next_count = 10'h000;
                next_en = 1'b1;
            end else begin
                next_count = count + 10'h001;
            end
        end else begin
            next_count = 10'h000;
        end
    end

    // Registers the counter and pulse.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 10'h000;
            cpu_clk_en <= 1'b0;
        end else begin
            count <= next_count;
            cpu_clk_en <= next_en;
        end
    end

endmodule : ccpm_divider

// ===== verilog/ccpm_top.sv
/*
 * CPU clock and power manager: clock divide, brownout and power-on
 * monitoring, idle and power-down control, wake-up stability count.
 * Assumes an APB master, asynchronous detector levels, and a core that
 * stalls while core_clk_en is low.
 */
// Our own choices: register access over APB and the placing of the registers.
// How it works
// - Halving option doubles the CPU clock period
// - Halving also slows peripheral timing
// - Divider zero: undivided or halved oscillator
// - Divider N divides by 2(N+1)
// - Divider changes apply at once, glitch-free
// - Brownout resets, or interrupts when select set
// - Brownout reset held while supply low
// - Brownout interrupt only on falling edge
// - Brownout interrupt needs global and own enable
// - Brownout flag sticky until software clears
// - Level select one low, zero high threshold
// - Disable bit kills brownout reset and interrupt
// - Power-up flag sticky until software clears
// - Idle stops CPU; interrupt or reset ends
// - Power-down stops oscillator
// - Power-down ends on reset or wake interrupt
// - Brownout wakes or resets during power-down
// - Wake waits 1024 or 256 clocks
// - Watchdog resets even in power-down
// - Brownout and watchdog run in power-down
// - Request bits clear when mode ends
// - Flag bit positions; brownout flag set at power-on
`include "ccpm_regs.svh"
module ccpm_top
    import ccpm_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Detectors.
    input wire logic brownout_low,
    input wire logic power_on_det,
    input wire logic watchdog_ovf,
    // Interrupt controller.
    input wire logic wake_irq,
    input wire logic any_irq,
    // Core side.
    output logic cpu_clk_en,
    output logic core_clk_en,
    output logic periph_clk_en,
    output logic osc_enable,
    output logic brownout_irq,
    output logic brownout_reset,
    output logic watchdog_reset,
    output logic brownout_level_select
);

    // ****************************************************************
    // Detector synchronisers
    // ****************************************************************
    ccpm_det_s det_meta; // First stage, read only by the second.
    ccpm_det_s det_sync; // Second stage.
    ccpm_det_s det_prev; // Previous synced value for edges.

    // Two-flop synchroniser for the detector levels.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            det_meta <= '0;
            det_sync <= '0;
            det_prev <= '0;
        end else begin
            det_meta <= '{brownout_low, power_on_det, watchdog_ovf};
            det_sync <= det_meta;
            det_prev <= det_sync;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0] power_control_reg; // Flags and mode requests.
    logic [7:0] cpu_clock_divider; // Programmable divider value.
    logic [7:0] aux_control_reg; // Brownout select and disable.
    logic [7:0] irq_enable_reg_zero; // Global and brownout enables.
    logic [7:0] config_byte_one; // Configuration bits.
    logic [7:0] next_pc;
    logic [7:0] next_div;
    logic [7:0] next_aux;
    logic [7:0] next_ie;
    logic [7:0] next_cfg;
    logic [31:0] next_rdata;
    logic wr_en; // Write takes effect this cycle.
    logic rd_en; // Read data sampled this cycle.
    logic addr_ok; // Address is mapped.
    logic bo_active; // Brownout detection enabled and supply low.
    logic bo_fall; // Supply just crossed below threshold.
    logic bo_irq_mode;
    logic mode_end; // Idle or power-down terminates.

    ccpm_state_e state;
    ccpm_state_e next_state;
    logic [10:0] wake_count;
    logic [10:0] next_wake_count;

    // Decodes the access phase; the slave always answers at once.
    always_comb begin
        wr_en = psel && penable && pwrite;
        rd_en = psel && penable && !pwrite;
        case (paddr)
            `CCPM_OFS_PWR_CTRL, `CCPM_OFS_DIVIDER, `CCPM_OFS_AUX_CTRL,
            `CCPM_OFS_IRQ_EN, `CCPM_OFS_CONFIG, `CCPM_OFS_STATUS: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // Brownout qualification and edge.
    always_comb begin
        bo_active = det_sync.brownout && !aux_control_reg[`CCPM_AUX_BOD];
        bo_fall = bo_active && !det_prev.brownout;
        bo_irq_mode = aux_control_reg[`CCPM_AUX_BOI];
    end

    // Next values for the register file, including hardware flag sets.
    always_comb begin
        next_pc = power_control_reg;
        next_div = cpu_clock_divider;
        next_aux = aux_control_reg;
        next_ie = irq_enable_reg_zero;
        next_cfg = config_byte_one;
        if (wr_en) begin
            case (paddr)
                `CCPM_OFS_PWR_CTRL: next_pc = pwdata[7:0];
                `CCPM_OFS_DIVIDER: next_div = pwdata[7:0];
                `CCPM_OFS_AUX_CTRL: next_aux = pwdata[7:0] & 8'h60;
                `CCPM_OFS_IRQ_EN: next_ie = pwdata[7:0] & 8'hA0;
                `CCPM_OFS_CONFIG: next_cfg = pwdata[7:0] & 8'h07;
                default: next_pc = power_control_reg;
            endcase
        end
        // Hardware sets win over a software clear in the same cycle.
        if (bo_active) begin
            next_pc[`CCPM_PC_BOF] = 1'b1;
        end
        if (det_sync.power_on) begin
            next_pc[`CCPM_PC_POF] = 1'b1;
            next_pc[`CCPM_PC_BOF] = 1'b1;
        end
        // A brownout or watchdog reset also ends either mode; otherwise the
        // still-set request bit would send the core straight back down.
        if (mode_end || brownout_reset || watchdog_reset) begin
            next_pc[`CCPM_PC_DOZE] = 1'b0;
            next_pc[`CCPM_PC_SLEEP] = 1'b0;
        end
    end

    // Registers the register file.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_control_reg <= `CCPM_RST_PC;
            cpu_clock_divider <= `CCPM_RST_DIV;
            aux_control_reg <= `CCPM_RST_AUX;
            irq_enable_reg_zero <= `CCPM_RST_IE;
            config_byte_one <= `CCPM_RST_CFG;
            prdata <= 32'h0000_0000;
        end else begin
            power_control_reg <= next_pc;
            cpu_clock_divider <= next_div;
            aux_control_reg <= next_aux;
            irq_enable_reg_zero <= next_ie;
            config_byte_one <= next_cfg;
            prdata <= next_rdata;
        end
    end

    // Read mux; status shows state and synced detectors.
    always_comb begin
        next_rdata = prdata;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `CCPM_OFS_PWR_CTRL: next_rdata = {24'h000000, power_control_reg};
                `CCPM_OFS_DIVIDER: next_rdata = {24'h000000, cpu_clock_divider};
                `CCPM_OFS_AUX_CTRL: next_rdata = {24'h000000, aux_control_reg};
                `CCPM_OFS_IRQ_EN: next_rdata = {24'h000000, irq_enable_reg_zero};
                `CCPM_OFS_CONFIG: next_rdata = {24'h000000, config_byte_one};
                `CCPM_OFS_STATUS: next_rdata = {25'h0000000, det_sync, state};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // Power state machine
    // ****************************************************************
    logic wake_req; // Any interrupt cause to leave power-down.

    // Next state and wake count.
    always_comb begin
        next_state = state;
        next_wake_count = wake_count;
        mode_end = 1'b0;
        wake_req = wake_irq ||
            (bo_fall && bo_irq_mode && irq_enable_reg_zero[`CCPM_IE_EBO]
             && irq_enable_reg_zero[`CCPM_IE_EA]);
        case (state)
            CCPM_RUN: begin
                if (power_control_reg[`CCPM_PC_SLEEP]) begin
                    next_state = CCPM_DOWN;
                end else if (power_control_reg[`CCPM_PC_DOZE]) begin
                    next_state = CCPM_IDLE;
                end
            end
            CCPM_IDLE: begin
                if (any_irq || wake_req) begin
                    next_state = CCPM_RUN;
                    mode_end = 1'b1;
                end
            end
            CCPM_DOWN: begin
                if (wake_req) begin
                    next_state = CCPM_WAKE;
                    next_wake_count = 11'h000;
                end
            end
            CCPM_WAKE: begin
                if (cpu_clk_en) begin
                    next_wake_count = wake_count + 11'h001;
                end
                if (wake_count >= (config_byte_one[`CCPM_CFG_XTAL] ?
                        `CCPM_WAKE_XTAL : `CCPM_WAKE_RC)) begin
                    next_state = CCPM_RUN;
                    mode_end = 1'b1;
                end
            end
            default: next_state = CCPM_RUN;
        endcase
    end

    // Registers the power state; brownout or watchdog reset returns to run.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= CCPM_RUN;
            wake_count <= 11'h000;
        end else if (brownout_reset || watchdog_reset) begin
            state <= CCPM_RUN;
            wake_count <= 11'h000;
        end else begin
            state <= next_state;
            wake_count <= next_wake_count;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Oscillator is stopped only while in power-down.
    assign osc_enable = (state != CCPM_DOWN);
    assign core_clk_en = cpu_clk_en && (state == CCPM_RUN);
    assign periph_clk_en = cpu_clk_en;
    assign brownout_reset = bo_active && !bo_irq_mode;
    assign brownout_irq = bo_fall && bo_irq_mode &&
        irq_enable_reg_zero[`CCPM_IE_EBO] && irq_enable_reg_zero[`CCPM_IE_EA];
    assign watchdog_reset = det_sync.watchdog;
    assign brownout_level_select = config_byte_one[`CCPM_CFG_BOV];

    // Clock divider; counts only while the oscillator runs.
    ccpm_divider u_div (
        .clk(clk),
        .rst_n(rst_n),
        .run(osc_enable),
        .half_speed_compat(config_byte_one[`CCPM_CFG_HALF]),
        .cpu_clock_divider(cpu_clock_divider),
        .cpu_clk_en(cpu_clk_en)
    );

endmodule : ccpm_top

// ===== verif/ccpm_assertions.sv
/*
 * Port-level checker for the clock and power manager.
 * Assumes it is bound to ccpm_top and sees only its ports.
 */
module ccpm_assertions
    import ccpm_pkg::*;
(
    // Clock, reset and bus.
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Detectors and core side.
    input wire logic brownout_low,
    input wire logic watchdog_ovf,
    input wire logic cpu_clk_en,
    input wire logic core_clk_en,
    input wire logic periph_clk_en,
    input wire logic osc_enable,
    input wire logic brownout_irq,
    input wire logic brownout_reset,
    input wire logic watchdog_reset
);
// ****************************************************************
// Properties
// ****************************************************************
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_n);
// The slave never inserts wait states.
bus_ready_a: assert property (pready) else $error("pready low");
// Accesses beyond the last register are refused.
bus_refuse_a: assert property (psel && penable && paddr > 12'h014 |-> pslverr)
    else $error("no slave error");
core_gate_a: assert property (core_clk_en |-> cpu_clk_en) else $error("core gate");
periph_run_a: assert property (periph_clk_en == cpu_clk_en) else $error("periph");
bo_reset_a: assert property (brownout_reset |-> $past(brownout_low, 2))
    else $error("brownout reset without low supply");
bo_once_a: assert property (brownout_irq |=> !brownout_irq) else $error("irq twice");
bo_edge_a: assert property (brownout_irq |-> $past(brownout_low, 2) &&
    !$past(brownout_low, 3)) else $error("irq not on edge");
bo_mode_a: assert property (brownout_irq |-> !brownout_reset)
    else $error("irq and reset together");
wdog_sync_a: assert property (watchdog_reset == $past(watchdog_ovf, 2))
    else $error("watchdog reset");
down_stop_a: assert property (!osc_enable |-> !core_clk_en) else $error("core runs");
wake_hold_a: assert property ($rose(osc_enable) && !$past(watchdog_reset) &&
    !$past(brownout_reset) |-> !core_clk_en [*8])
    else $error("core runs before stable");
endmodule : ccpm_assertions

bind ccpm_top ccpm_assertions chk (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .brownout_low(brownout_low), .watchdog_ovf(watchdog_ovf),
    .cpu_clk_en(cpu_clk_en), .core_clk_en(core_clk_en),
    .periph_clk_en(periph_clk_en), .osc_enable(osc_enable),
    .brownout_irq(brownout_irq), .brownout_reset(brownout_reset),
    .watchdog_reset(watchdog_reset));

// ===== verif/ccpm_partner.sv
/*
 * Model of the core and interrupt controller beside the manager.
 * Assumes the bench commands which interrupt levels are pending.
 */
module ccpm_partner
    import ccpm_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // From the manager and the bench.
    input wire logic core_clk_en,
    input wire logic brownout_irq,
    input wire logic wake_cmd,
    input wire logic any_cmd,
    // To the manager and the bench.
    output logic wake_irq,
    output logic any_irq,
    output logic [15:0] core_cnt,
    output logic [15:0] irq_cnt
);
// Pending levels follow the commanded sources.
assign wake_irq = wake_cmd;
assign any_irq = any_cmd;
// Count executed core cycles and taken brownout interrupts.
always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        core_cnt <= 16'h0000;
        irq_cnt <= 16'h0000;
    end else begin
        core_cnt <= core_cnt + {15'h0000, core_clk_en};
        irq_cnt <= irq_cnt + {15'h0000, brownout_irq};
    end
end
endmodule : ccpm_partner

// ===== verif/ccpm_tb.sv
/*
 * Self-checking bench for the clock and power manager.
 * Assumes the design files and the register header are compiled first.
 */
`include "ccpm_regs.svh"
module test_ccpm_top;
import ccpm_pkg::*;
timeunit 1ns;
timeprecision 1ns;
// ****************************************************************
// Signals
// ****************************************************************
logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0, prdata, r;
logic pready, pslverr, e, bo = 0, po = 0, wd = 0, wk = 0, an = 0;
logic wake_irq, any_irq, cpu_clk_en, core_clk_en, periph_clk_en, osc_enable;
logic brownout_irq, brownout_reset, watchdog_reset, brownout_level_select;
logic [15:0] core_cnt, irq_cnt, c;
int n_errors = 0, tests_run = 0;
ccpm_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .brownout_low(bo), .power_on_det(po),
    .watchdog_ovf(wd), .wake_irq(wake_irq), .any_irq(any_irq),
    .cpu_clk_en(cpu_clk_en), .core_clk_en(core_clk_en),
    .periph_clk_en(periph_clk_en), .osc_enable(osc_enable),
    .brownout_irq(brownout_irq), .brownout_reset(brownout_reset),
    .watchdog_reset(watchdog_reset), .brownout_level_select(brownout_level_select));
ccpm_partner cpu (.clk(clk), .rst_n(rst_n), .core_clk_en(core_clk_en),
    .brownout_irq(brownout_irq), .wake_cmd(wk), .any_cmd(an), .wake_irq(wake_irq),
    .any_irq(any_irq), .core_cnt(core_cnt), .irq_cnt(irq_cnt));
// ****************************************************************
// Tasks
// ****************************************************************
// One APB transfer; waits on pready and takes data at that edge.
task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
endtask : apb
// Compare a value with its expectation.
task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
        n_errors++;
        $display("ERROR %0t got %h expected %h", $time, g, x);
    end
endtask : chk
task automatic w(input int n);
    repeat (n) @(posedge clk);
endtask : w
// Cycles between two CPU clock enables.
task automatic per(output logic [31:0] n);
    n = 0;
    @(posedge clk);
    while (cpu_clk_en !== 1'b1) @(posedge clk);
    do begin @(posedge clk); n++; end while (cpu_clk_en !== 1'b1);
endtask : per
task automatic stop_test;
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
endtask : stop_test
// Reset values and a refused access.
task automatic t_regs;
    apb(0, `CCPM_OFS_PWR_CTRL, 0); chk(r, 32'h30);
    apb(0, `CCPM_OFS_DIVIDER, 0); chk(r, 32'h0);
    apb(0, `CCPM_OFS_CONFIG, 0); chk(r, 32'h2);
    apb(0, 12'h018, 0); chk({r[31:1], e}, 32'h1);
    apb(1, `CCPM_OFS_PWR_CTRL, 0); apb(0, `CCPM_OFS_PWR_CTRL, 0); chk(r, 32'h0);
    po <= 1; w(5); po <= 0;
    apb(0, `CCPM_OFS_PWR_CTRL, 0); chk(r, 32'h30);
    apb(1, `CCPM_OFS_CONFIG, 0); w(1); chk(brownout_level_select, 0);
endtask : t_regs
// Divider ratios, changed while running.
task automatic t_div;
    logic [31:0] x;
    logic [8:0] tb [5] = '{9'h000, 9'h100, 9'h001, 9'h0FF, 9'h102};
    logic [31:0] ex [5] = '{1, 2, 4, 512, 12};
    for (int i = 0; i < 5; i++) begin
        apb(1, `CCPM_OFS_CONFIG, {30'h0, 1'b1, tb[i][8]});
        apb(1, `CCPM_OFS_DIVIDER, {24'h0, tb[i][7:0]});
        per(x); per(x); chk(x, ex[i]);
    end
    apb(1, `CCPM_OFS_CONFIG, 32'h2); apb(1, `CCPM_OFS_DIVIDER, 0);
endtask : t_div
// Brownout in reset, interrupt, unenabled and disabled forms.
task automatic t_bo;
    apb(1, `CCPM_OFS_PWR_CTRL, 0);
    bo <= 1; w(5); chk(brownout_reset, 1); bo <= 0; w(5);
    chk(brownout_reset, 0); apb(0, `CCPM_OFS_PWR_CTRL, 0); chk(r[5], 1);
    apb(1, `CCPM_OFS_AUX_CTRL, 32'h20); apb(1, `CCPM_OFS_IRQ_EN, 32'hA0);
    c = irq_cnt; bo <= 1; w(20);
    chk(irq_cnt, c + 1); chk(brownout_reset, 0); bo <= 0; w(5);
    apb(1, `CCPM_OFS_IRQ_EN, 32'h80); bo <= 1; w(8); chk(irq_cnt, c + 1);
    bo <= 0; apb(1, `CCPM_OFS_IRQ_EN, 32'hA0); apb(1, `CCPM_OFS_AUX_CTRL, 32'h60);
    bo <= 1; w(8); chk({irq_cnt, 15'h0, brownout_reset}, {c + 16'h1, 16'h0});
    bo <= 0; apb(1, `CCPM_OFS_AUX_CTRL, 0);
endtask : t_bo
// Idle ends on a pending interrupt.
task automatic t_idle;
    apb(1, `CCPM_OFS_PWR_CTRL, 1); w(3); c = core_cnt; w(10);
    chk(core_cnt, c); an <= 1; w(5); an <= 0; chk(core_cnt > c, 1);
    apb(0, `CCPM_OFS_PWR_CTRL, 0); chk(r[1:0], 0);
endtask : t_idle
// Power-down, wake with stability count, watchdog while down.
task automatic t_down;
    apb(1, `CCPM_OFS_PWR_CTRL, 2); w(3); chk(osc_enable, 0);
    wk <= 1; w(4); wk <= 0; chk(osc_enable, 1);
    w(190); apb(0, `CCPM_OFS_STATUS, 0); chk(r[3:0], CCPM_WAKE);
    w(100); apb(0, `CCPM_OFS_STATUS, 0); chk(r[3:0], CCPM_RUN);
    apb(0, `CCPM_OFS_PWR_CTRL, 0); chk(r[1:0], 0);
    apb(1, `CCPM_OFS_PWR_CTRL, 2); w(3); wd <= 1; w(4);
    chk(watchdog_reset, 1); wd <= 0; w(4);
    apb(0, `CCPM_OFS_PWR_CTRL, 0); chk(r[1:0], 0);
    apb(0, `CCPM_OFS_STATUS, 0); chk(r[3:0], CCPM_RUN);
endtask : t_down
// ****************************************************************
// Clock, watchdog and sequence
// ****************************************************************
initial begin
    forever #10 clk = ~clk;
end
initial begin
    w(20000);
    n_errors++;
    stop_test();
end
initial begin
    w(20);
    rst_n <= 1;
    t_regs();
    t_div();
    t_bo();
    t_idle();
    t_down();
    stop_test();
end
endmodule : test_ccpm_top
